//--- ccg_pkg.sv
// Package: register map, field layout and types of the CPU clock generator
package ccg_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [15:0] CCG_MULT_IDX   = 16'hff6c;
   localparam logic [15:0] CCG_SEL_IDX    = 16'hfffb;
   localparam logic [15:0] CCG_STAT_IDX   = 16'hff00;
   localparam int          CCG_AW         = 18;
   localparam logic [7:0]  CCG_SEL_RST    = 8'h02;
   localparam logic [7:0]  CCG_MULT_RST   = 8'h00;
   // Divider field codes
   localparam logic [1:0]  CCG_DIV1       = 2'h0;
   localparam logic [1:0]  CCG_DIV2       = 2'h1;
   localparam logic [1:0]  CCG_DIV4       = 2'h2;
   localparam logic [1:0]  CCG_DIV_BAD    = 2'h3;
   // Field positions
   localparam int          CCG_SEL_LO_POS = 0;
   localparam int          CCG_SEL_HI_POS = 1;
   localparam int          CCG_MULT_POS   = 0;
   // Stabilisation wait exponent, in oscillator cycles
   localparam int          CCG_STAB_EXP   = 15;
   // Worst switch latency in fx cycles for this design
   localparam logic [2:0]  CCG_SW_MAX     = 3'h4;
   localparam logic [1:0]  CCG_RESP_OK    = 2'h0;
   localparam logic [1:0]  CCG_RESP_SLV   = 2'h2;
   localparam int          CCG_PRE_W      = 8;

   typedef struct packed {
      logic                awvalid;
      logic [CCG_AW-1:0]   awaddr;
      logic                wvalid;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
      logic                bready;
      logic                arvalid;
      logic [CCG_AW-1:0]   araddr;
      logic                rready;
   } ccg_axi_req_t;

   typedef struct packed {
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
   } ccg_axi_rsp_t;

   // Clock enables handed to the rest of the chip
   typedef struct packed {
      logic                osc_run;
      logic                cpu_run;
      logic                cpu_clk_en;
      logic                instr_tick;
      logic                mult_clk_en;
      logic [3:0]          periph_clk_en;
   } ccg_clk_t;

   typedef enum logic [4:0] {
      CCG_S_OFF   = 5'b00001,
      CCG_S_STAB  = 5'b00010,
      CCG_S_RUN   = 5'b00100,
      CCG_S_PAUSE = 5'b01000,
      CCG_S_STOP  = 5'b10000
   } ccg_state_t;
endpackage

//--- ccg_top.sv
// CPU clock generator: dividers, standby modes, AXI4-Lite registers
`timescale 1ns/1ps
module ccg_top
   import ccg_pkg::*;
#(
   parameter int STAB_CYCLES = 1 << CCG_STAB_EXP
)(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic         stop_req,
   input  wire logic         pause_req,
   input  wire logic         wake_pin,
   input  wire ccg_axi_req_t axi_req,
   output      ccg_axi_rsp_t axi_rsp,
   output      ccg_clk_t     clk_out
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic tick_of(input logic [1:0] sel,
                                    input logic [1:0] cnt);
      case (sel)
         CCG_DIV1: tick_of = 1'b1;
         CCG_DIV2: tick_of = cnt[0];
         CCG_DIV4: tick_of = (cnt == 2'h3);
         default:  tick_of = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] idx_of(input logic [CCG_AW-1:0] a);
      idx_of = a[17:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Wake pin synchroniser

   logic wake_s1_ff;
   logic wake_s2_ff;

   // First stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_s1_ff <= 1'b0;
         wake_s2_ff <= 1'b0;
      end else if (ce) begin
         wake_s1_ff <= wake_pin;
         wake_s2_ff <= wake_s1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and AXI4-Lite slave

   logic [1:0]   div_sel_ff, nxt_div_sel;
   logic         mult_en_ff, nxt_mult_en;
   logic         aw_have_ff, nxt_aw_have;
   logic         w_have_ff,  nxt_w_have;
   logic [15:0]  aw_idx_ff,  nxt_aw_idx;
   logic [31:0]  wdat_ff,    nxt_wdat;
   logic         wlane_ff,   nxt_wlane;
   ccg_axi_rsp_t rsp_ff,     nxt_rsp;
   logic [1:0]   act_sel_ff;
   logic         sw_busy;
   ccg_state_t   st_ff;
   logic         osc_run_ff;

   // Address and data may arrive in either order; answer once both held
   always_comb begin
      nxt_div_sel  = div_sel_ff;
      nxt_mult_en  = mult_en_ff;
      nxt_aw_have  = aw_have_ff;
      nxt_w_have   = w_have_ff;
      nxt_aw_idx   = aw_idx_ff;
      nxt_wdat     = wdat_ff;
      nxt_wlane    = wlane_ff;
      nxt_rsp      = rsp_ff;
      if (rsp_ff.awready && axi_req.awvalid) begin
         nxt_aw_have = 1'b1;
         nxt_aw_idx  = idx_of(axi_req.awaddr);
      end
      if (rsp_ff.wready && axi_req.wvalid) begin
         nxt_w_have = 1'b1;
         nxt_wdat   = axi_req.wdata;
         nxt_wlane  = axi_req.wstrb[0];
      end
      if (rsp_ff.bvalid && axi_req.bready)
         nxt_rsp.bvalid = 1'b0;
      if (aw_have_ff && w_have_ff && !rsp_ff.bvalid) begin
         nxt_aw_have   = 1'b0;
         nxt_w_have    = 1'b0;
         nxt_rsp.bvalid = 1'b1;
         nxt_rsp.bresp  = CCG_RESP_OK;
         case (aw_idx_ff)
            CCG_SEL_IDX: begin
               // Barred code 11 is dropped; bits 7:2 are not stored
               if (wlane_ff && wdat_ff[1:0] != CCG_DIV_BAD)
                  nxt_div_sel = wdat_ff[1:0];
            end
            CCG_MULT_IDX: begin
               if (wlane_ff)
                  nxt_mult_en = wdat_ff[CCG_MULT_POS];
            end
            CCG_STAT_IDX: ;
            default: nxt_rsp.bresp = CCG_RESP_SLV;
         endcase
      end
      nxt_rsp.awready = !nxt_aw_have && !nxt_rsp.bvalid;
      nxt_rsp.wready  = !nxt_w_have && !nxt_rsp.bvalid;
      // Read: one outstanding, answered the cycle after the address
      if (rsp_ff.rvalid && axi_req.rready)
         nxt_rsp.rvalid = 1'b0;
      if (rsp_ff.arready && axi_req.arvalid) begin
         nxt_rsp.rvalid = 1'b1;
         nxt_rsp.rresp  = CCG_RESP_OK;
         nxt_rsp.rdata  = 32'h0;
         case (idx_of(axi_req.araddr))
            CCG_SEL_IDX:  nxt_rsp.rdata[1:0] = div_sel_ff;
            CCG_MULT_IDX: nxt_rsp.rdata[0]   = mult_en_ff;
            CCG_STAT_IDX: nxt_rsp.rdata[8:0] = {st_ff, osc_run_ff,
                                                sw_busy, act_sel_ff};
            default:      nxt_rsp.rresp      = CCG_RESP_SLV;
         endcase
      end
      nxt_rsp.arready = !nxt_rsp.rvalid;
   end

   // Reset loads slow mode and a stopped multiplier
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_sel_ff <= CCG_SEL_RST[1:0];
         mult_en_ff <= CCG_MULT_RST[0];
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         aw_idx_ff  <= 16'h0;
         wdat_ff    <= 32'h0;
         wlane_ff   <= 1'b0;
         rsp_ff     <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                         default: '0};
      end else if (ce) begin
         div_sel_ff <= nxt_div_sel;
         mult_en_ff <= nxt_mult_en;
         aw_have_ff <= nxt_aw_have;
         w_have_ff  <= nxt_w_have;
         aw_idx_ff  <= nxt_aw_idx;
         wdat_ff    <= nxt_wdat;
         wlane_ff   <= nxt_wlane;
         rsp_ff     <= nxt_rsp;
      end
   end

   assign axi_rsp = rsp_ff;

   ////////////////////////////////////////////////////////////////////////
   // Oscillator and standby state machine

   ccg_state_t        nxt_st;
   logic [CCG_AW:0]   stab_cnt_ff, nxt_stab_cnt;

   always_comb begin
      nxt_st       = st_ff;
      nxt_stab_cnt = stab_cnt_ff;
      case (st_ff)
         CCG_S_OFF: begin
            nxt_st       = CCG_S_STAB;
            nxt_stab_cnt = (CCG_AW+1)'(STAB_CYCLES - 1);
         end
         CCG_S_STAB: begin
            if (stab_cnt_ff == '0)
               nxt_st = CCG_S_RUN;
            else
               nxt_stab_cnt = stab_cnt_ff - 1'b1;
         end
         CCG_S_RUN: begin
            if (stop_req)
               nxt_st = CCG_S_STOP;
            else if (pause_req)
               nxt_st = CCG_S_PAUSE;
         end
         CCG_S_PAUSE: begin
            if (wake_s2_ff)
               nxt_st = CCG_S_RUN;
         end
         CCG_S_STOP: begin
            // Restarted crystal needs the same settling time
            if (wake_s2_ff) begin
               nxt_st       = CCG_S_STAB;
               nxt_stab_cnt = (CCG_AW+1)'(STAB_CYCLES - 1);
            end
         end
         default: nxt_st = CCG_S_OFF;
      endcase
   end

   // Oscillator held off throughout reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff       <= CCG_S_OFF;
         stab_cnt_ff <= '0;
      end else if (ce) begin
         st_ff       <= nxt_st;
         stab_cnt_ff <= nxt_stab_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dividers, switch point and clock enables

   logic [CCG_PRE_W-1:0] pre_ff, nxt_pre;
   logic [1:0]           nxt_act_sel;
   logic                 instr_ph_ff, nxt_instr_ph;
   logic                 nxt_osc_run;
   logic                 sw_pt;
   logic                 old_tick;
   ccg_clk_t             clk_ff, nxt_clk;

   assign sw_busy  = (act_sel_ff != div_sel_ff);
   // All three ratios end a period together when the low bits are 11
   assign sw_pt    = osc_run_ff && (pre_ff[1:0] == 2'h3);
   assign old_tick = tick_of(act_sel_ff, pre_ff[1:0]);

   always_comb begin
      nxt_osc_run  = (nxt_st != CCG_S_OFF) && (nxt_st != CCG_S_STOP);
      nxt_pre      = osc_run_ff ? pre_ff + 1'b1 : pre_ff;
      nxt_act_sel  = sw_busy && sw_pt ? div_sel_ff : act_sel_ff;
      nxt_instr_ph = instr_ph_ff;
      nxt_clk      = '0;
      nxt_clk.osc_run = osc_run_ff;
      nxt_clk.cpu_run = (st_ff == CCG_S_RUN);
      if (st_ff == CCG_S_RUN && osc_run_ff && old_tick) begin
         nxt_clk.cpu_clk_en = 1'b1;
         nxt_clk.instr_tick = instr_ph_ff;
         nxt_instr_ph       = !instr_ph_ff;
      end
      nxt_clk.mult_clk_en = osc_run_ff && mult_en_ff;
      if (osc_run_ff) begin
         nxt_clk.periph_clk_en[0] = &pre_ff[0:0];
         nxt_clk.periph_clk_en[1] = &pre_ff[1:0];
         nxt_clk.periph_clk_en[2] = &pre_ff[3:0];
         nxt_clk.periph_clk_en[3] = &pre_ff[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_run_ff  <= 1'b0;
         pre_ff      <= '0;
         act_sel_ff  <= CCG_SEL_RST[1:0];
         instr_ph_ff <= 1'b0;
         clk_ff      <= '0;
      end else if (ce) begin
         osc_run_ff  <= nxt_osc_run;
         pre_ff      <= nxt_pre;
         act_sel_ff  <= nxt_act_sel;
         instr_ph_ff <= nxt_instr_ph;
         clk_ff      <= nxt_clk;
      end
   end

   assign clk_out = clk_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks; ce low freezes the block, so checks pause with it

   logic [2:0] pend_cnt_ff;
   logic [CCG_AW:0] stab_len_ff;

   // Counts settling cycles apart from the down counter it checks
   always_ff @(posedge aclk) begin
      if (!aresetn)
         stab_len_ff <= '0;
      else if (ce)
         stab_len_ff <= (st_ff == CCG_S_STAB) ? stab_len_ff + 1'b1 : '0;
   end

   // Counts running fx cycles spent with a switch outstanding
   always_ff @(posedge aclk) begin
      if (!aresetn || !sw_busy)
         pend_cnt_ff <= 3'h0;
      else if (ce && osc_run_ff && pend_cnt_ff != 3'h7)
         pend_cnt_ff <= pend_cnt_ff + 3'h1;
   end

   reset_values_a: assert property (@(posedge aclk)
      disable iff (!ce)
      !aresetn |=> (div_sel_ff == CCG_SEL_RST[1:0] && !mult_en_ff))
      else $error("divider or multiplier wrong after reset");

   osc_in_reset_a: assert property (@(posedge aclk)
      disable iff (!ce)
      !aresetn |=> !osc_run_ff && !clk_ff.cpu_clk_en)
      else $error("oscillator running during reset");

   stop_osc_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      (st_ff == CCG_S_RUN && stop_req) |=> ##1 !osc_run_ff)
      else $error("stop did not halt oscillator");

   stab_wait_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      (st_ff == CCG_S_RUN && stab_len_ff != '0) |-> stab_len_ff >= STAB_CYCLES)
      else $error("CPU started before stabilisation");

   div4_gap_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      (clk_ff.cpu_clk_en && act_sel_ff == CCG_DIV4)
         |=> !clk_ff.cpu_clk_en [*2])
      else $error("quarter clock ticked too often");

   instr_two_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      clk_ff.instr_tick |-> clk_ff.cpu_clk_en ##1 !clk_ff.instr_tick)
      else $error("instruction tick not every two clocks");

   mult_gate_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      !mult_en_ff |=> !clk_ff.mult_clk_en)
      else $error("doubled clock with multiplier off");

   periph_stop_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      !osc_run_ff |=> clk_ff.periph_clk_en == 4'h0)
      else $error("peripheral clock without oscillator");

   switch_late_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      pend_cnt_ff <= CCG_SW_MAX)
      else $error("clock switch took too long");

   switch_edge_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      (act_sel_ff != $past(act_sel_ff)) |-> $past(pre_ff[1:0]) == 2'h3)
      else $error("clock switched off a period boundary");

   pause_gate_a: assert property (@(posedge aclk)
      disable iff (!aresetn || !ce)
      (st_ff == CCG_S_PAUSE) [*2] |-> !clk_ff.cpu_clk_en && osc_run_ff)
      else $error("CPU clock ran in pause");

endmodule

//--- ccg_osc_model.sv
// Oscillator model: the fx source standing beside the clock generator
`timescale 1ns/1ps
module ccg_osc_model (
   output logic aclk
);
   // Runs free; the generator gates its outputs by enables, so a stopped
   // oscillator shows up only through osc_run and the enable outputs
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
endmodule

//--- testbench.sv
// Self-checking bench of the CPU clock generator
`timescale 1ns/1ps
module testbench
   import ccg_pkg::*;
;
   localparam int STAB  = 16;
   localparam int LIMIT = 4000;
   typedef struct packed {
      logic [31:0] d;
      logic [1:0]  r;
   } ccg_exp_t;
   logic         aclk;
   logic         aresetn;
   logic         stop_req;
   logic         pause_req;
   logic         wake_pin;
   ccg_axi_req_t req;
   ccg_axi_rsp_t rsp;
   ccg_clk_t     clk;
   ccg_exp_t     rq[$];
   logic [1:0]   bq[$];
   int           miscompares;
   int           checked;
   int           cycles = 0;
   int           seed;

   ccg_osc_model osc (.aclk(aclk));
   ccg_top #(.STAB_CYCLES(STAB)) DUT (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (1'b1),
      .stop_req (stop_req),
      .pause_req(pause_req),
      .wake_pin (wake_pin),
      .axi_req  (req),
      .axi_rsp  (rsp),
      .clk_out  (clk)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                     input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      req.awaddr  <= {idx, 2'b00};
      req.awvalid <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (!(req.bready && rsp.bvalid));
      req.bready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] idx, input logic [31:0] d,
                     input logic [1:0] r);
      rq.push_back('{d, r});
      @(posedge aclk);
      req.araddr  <= {idx, 2'b00};
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!(req.rready && rsp.rvalid));
      req.rready <= 1'b0;
   endtask

   // Window of n cycles: CPU pulses, instruction ticks, and peripheral
   // pulses packed one tap per byte (fx/2 in the lowest byte)
   task automatic cnt(input int n, output int c, output int i, output int p);
      c = 0;
      i = 0;
      p = 0;
      repeat (n) begin
         @(posedge aclk);
         c += (clk.cpu_clk_en === 1'b1);
         i += (clk.instr_tick === 1'b1);
         p += int'(clk.periph_clk_en[0] === 1'b1);
         p += int'(clk.periph_clk_en[1] === 1'b1) << 8;
         p += int'(clk.periph_clk_en[2] === 1'b1) << 16;
         p += int'(clk.periph_clk_en[3] === 1'b1) << 24;
      end
   endtask

   task automatic do_reset;
      int n;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(clk.osc_run, 1'b0, "osc in reset");
      aresetn <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (clk.cpu_run !== 1'b1);
      chk(n >= STAB && n <= STAB + 6, 1, "stab wait");
   endtask

   // Wake level held until the CPU runs again; n counts the wait
   task automatic wake(output int n);
      wake_pin <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (clk.cpu_run !== 1'b1);
      wake_pin <= 1'b0;
      @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Response watcher: oldest note off the queue per response seen
   always @(posedge aclk) begin
      ccg_exp_t e;
      if (req.rready && rsp.rvalid) begin
         e = rq.pop_front();
         chk(rsp.rresp, e.r, "rresp");
         if (e.r === CCG_RESP_OK) chk(rsp.rdata, e.d, "rdata");
      end
      if (req.bready && rsp.bvalid)
         chk(rsp.bresp, bq.pop_front(), "bresp");
   end

   // Hang guard, well above the longest expected run
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int   c;
      int   i;
      int   p;
      int   n;
      logic v;
      seed        = 32'hf1c0;
      miscompares = 0;
      checked     = 0;
      req       <= '0;
      aresetn   <= 1'b0;
      stop_req  <= 1'b0;
      pause_req <= 1'b0;
      wake_pin  <= 1'b0;
      do_reset();
      rd(CCG_SEL_IDX, 32'h2, CCG_RESP_OK);
      rd(CCG_MULT_IDX, 32'h0, CCG_RESP_OK);
      cnt(16, c, i, p);
      chk(c, 4, "slow cpu clock");
      $display("test reset done");
      // Upper bits always zero from software; 16 cycles covers every bound
      for (int d = 0; d < 3; d++) begin
         wr(CCG_SEL_IDX, d, CCG_RESP_OK);
         repeat (16) @(posedge aclk);
         cnt(16, c, i, p);
         chk(c, 16 >> d, "cpu clock rate");
         chk(i, 8 >> d, "instruction rate");
         rd(CCG_SEL_IDX, d, CCG_RESP_OK);
      end
      wr(CCG_SEL_IDX, 32'h2, CCG_RESP_OK);
      rd(CCG_SEL_IDX, 32'h2, CCG_RESP_OK);
      wr(16'h0001, 32'h1, CCG_RESP_SLV);
      rd(16'h0001, 32'h0, CCG_RESP_SLV);
      $display("test divider done");
      repeat (4) begin
         v = $random(seed);
         wr(CCG_MULT_IDX, {31'h0, v}, CCG_RESP_OK);
         repeat (2) @(posedge aclk);
         chk(clk.mult_clk_en, v, "doubled clock");
         rd(CCG_MULT_IDX, {31'h0, v}, CCG_RESP_OK);
      end
      $display("test multiplier done");
      pause_req <= 1'b1;
      @(posedge aclk);
      pause_req <= 1'b0;
      repeat (3) @(posedge aclk);
      // A full prescaler cycle: 128, 64, 16 and 1 pulses per tap
      cnt(256, c, i, p);
      chk(c, 0, "cpu clock in pause");
      chk(p, 32'h01104080, "periph in pause");
      chk(clk.osc_run, 1'b1, "osc in pause");
      wake(n);
      chk(n <= 8, 1, "pause wake");
      $display("test pause done");
      stop_req <= 1'b1;
      @(posedge aclk);
      stop_req <= 1'b0;
      repeat (3) @(posedge aclk);
      cnt(16, c, i, p);
      chk(c + p, 0, "clocks in stop");
      chk(clk.osc_run, 1'b0, "osc in stop");
      wake(n);
      chk(n >= STAB && n <= STAB + 10, 1, "stop wake");
      $display("test stop done");
      // Second reset mid-run after the multiplier was changed; divider back at its reset value
      wr(CCG_MULT_IDX, 32'h1, CCG_RESP_OK);
      do_reset();
      rd(CCG_SEL_IDX, 32'h2, CCG_RESP_OK);
      rd(CCG_MULT_IDX, 32'h0, CCG_RESP_OK);
      chk(clk.mult_clk_en, 1'b0, "doubled clock off");
      // Status: state run, oscillator on, no switch pending, divider 10
      rd(CCG_STAT_IDX, 32'h4a, CCG_RESP_OK);
      $display("test second reset done");
      summarize();
   end
endmodule
